// ===== cmms_programmer.sv
// Programmer end: rewrites one erase block of code memory over the serial link
`timescale 1ns/1ps
module cmms_programmer import cmms_pkg::*; #(
    parameter int WRITE_BYTES   = DEF_WRITE_BYTES,
    parameter int ERASE_BYTES   = DEF_ERASE_BYTES,
    parameter int HALF_CYC      = DEF_HALF_CYC,
    parameter int PROG_HOLD_CYC = DEF_PROG_HOLD_CYC,
    parameter int DISCH_CYC     = DEF_DISCH_CYC
) (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           reset,
    // Block copy load port
    input  wire logic                           load_we,
    input  wire logic [$clog2(ERASE_BYTES)-1:0] load_index,
    input  wire logic [7:0]                     load_byte,
    // Sequence control
    input  wire logic                           start,
    input  wire logic [PTR_W-1:0]               block_addr,
    output logic                                busy,
    output logic                                done,
    // Link
    cmms_link_if.programmer                     link
);
    localparam int EI_W     = $clog2(ERASE_BYTES);
    localparam int OFF_W    = EI_W + 1;
    localparam int IDX_W    = $clog2(WRITE_BYTES) < 3 ? 3 : $clog2(WRITE_BYTES);
    localparam int TW       = $clog2(PROG_HOLD_CYC + 1);
    localparam int LAST_IDX = WRITE_BYTES / 2 - 1;

    if (WRITE_BYTES < 4 || (1 << $clog2(WRITE_BYTES)) != WRITE_BYTES || ERASE_BYTES < WRITE_BYTES
        || (1 << EI_W) != ERASE_BYTES || HALF_CYC < 1 || DISCH_CYC < 1
        || PROG_HOLD_CYC < HALF_CYC || PROG_HOLD_CYC < DISCH_CYC) begin : g_check
        $error("cmms_programmer: unsupported buffer sizes or timing counts");
    end

    typedef enum {
        ph_idle, ph_sel, ph_erptr, ph_arm, ph_ernop, ph_wrptr, ph_load, ph_last, ph_prnop, ph_dis
    } cmms_phase_t;

    typedef enum {eng_idle, eng_high, eng_low} cmms_eng_t;

    cmms_phase_t           phase;
    cmms_eng_t             eng;
    cmms_cmd_t             cmd;
    logic [IDX_W-1:0]      idx;
    logic [OFF_W-1:0]      off;
    logic [PTR_W-1:0]      base;
    logic [7:0]            blk [ERASE_BYTES];
    logic [EI_W-1:0]       cur;
    logic [FRAME_BITS-1:0] sh;
    logic                  hold_q;
    logic [4:0]            bitn;
    logic [TW-1:0]         timer;
    logic                  eng_done;

    // Six-instruction table pointer load
    function automatic logic [15:0] ptr_instr(input logic [2:0] i, input logic [PTR_W-1:0] a);
        unique case (i)
            3'h0:    ptr_instr = {OP_MOVLW, 2'b00, a[21:16]};
            3'h1:    ptr_instr = {OP_MOVWF, REG_PTR_U};
            3'h2:    ptr_instr = {OP_MOVLW, a[15:8]};
            3'h3:    ptr_instr = {OP_MOVWF, REG_PTR_H};
            3'h4:    ptr_instr = {OP_MOVLW, a[7:0]};
            3'h5:    ptr_instr = {OP_MOVWF, REG_PTR_L};
            default: ptr_instr = INS_NOP;
        endcase
    endfunction : ptr_instr

    // Block copy kept here, changed by the user before start
    always_ff @(posedge clock) begin
        if (load_we && !busy) begin
            blk[load_index] <= load_byte;
        end
    end

    // Command for the current step
    always_comb begin
        cur = EI_W'(off) + EI_W'({idx, 1'b0});
        cmd = '{hold: 1'b0, code: CMD_CORE, payload: INS_NOP};
        unique case (phase)
            ph_idle:  cmd.payload = INS_NOP;
            ph_sel:   cmd.payload = idx[0] ? INS_CLR_CFG : INS_SEL_PGM;
            ph_erptr: cmd.payload = ptr_instr(idx[2:0], base);
            ph_arm: begin
                if (idx == IDX_W'(0)) begin
                    cmd.payload = INS_SET_WR_EN;
                end else if (idx == IDX_W'(1)) begin
                    cmd.payload = INS_SET_FREE;
                end else begin
                    cmd.payload = INS_SET_WR;
                end
            end
            ph_ernop: cmd.hold = 1'b1;
            ph_wrptr: cmd.payload = ptr_instr(idx[2:0], base + PTR_W'(off));
            ph_load: begin
                cmd.code    = CMD_LOAD_INC;
                cmd.payload = {blk[cur | EI_W'(1)], blk[cur]};
            end
            ph_last: begin
                cmd.code    = CMD_LOAD_START;
                cmd.payload = {blk[cur | EI_W'(1)], blk[cur]};
            end
            ph_prnop: cmd.hold = 1'b1;
            ph_dis:   cmd.payload = INS_CLR_WR_EN;
        endcase
    end

    assign eng_done = (eng == eng_low) && (timer == TW'(1)) && (bitn == 5'(FRAME_BITS - 1));

    // Step sequencer
    always_ff @(posedge clock) begin
        if (reset) begin
            phase <= ph_idle;
            idx   <= '0;
            off   <= '0;
            base  <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (phase == ph_idle) begin
                if (start) begin
                    base  <= block_addr & ~PTR_W'(ERASE_BYTES - 1);
                    phase <= ph_sel;
                    idx   <= '0;
                    off   <= '0;
                    busy  <= 1'b1;
                end
            end else if (eng_done) begin
                idx <= idx + IDX_W'(1);
                unique case (phase)
                    ph_sel: begin
                        if (idx == IDX_W'(1)) begin
                            phase <= ph_erptr;
                            idx   <= '0;
                        end
                    end
                    ph_erptr: begin
                        if (idx == IDX_W'(5)) begin
                            phase <= ph_arm;
                            idx   <= '0;
                        end
                    end
                    ph_arm: begin
                        if (idx == IDX_W'(2)) begin
                            phase <= ph_ernop;
                        end
                    end
                    ph_ernop: begin
                        phase <= ph_wrptr;
                        idx   <= '0;
                    end
                    ph_wrptr: begin
                        if (idx == IDX_W'(5)) begin
                            phase <= (LAST_IDX == 1) ? ph_last : ph_load;
                            idx   <= '0;
                        end
                    end
                    ph_load: begin
                        if (idx == IDX_W'(LAST_IDX - 1)) begin
                            phase <= ph_last;
                        end
                    end
                    ph_last:  phase <= ph_prnop;
                    ph_prnop: begin
                        off <= off + OFF_W'(WRITE_BYTES);
                        idx <= '0;
                        if (off + OFF_W'(WRITE_BYTES) == OFF_W'(ERASE_BYTES)) begin
                            phase <= ph_dis;
                        end else begin
                            phase <= ph_wrptr;
                        end
                    end
                    ph_dis: begin
                        phase <= ph_idle;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end
                    ph_idle: phase <= ph_idle;
                endcase
            end
        end
    end

    // Bit engine: data set with each rising clock, device takes it on the fall
    always_ff @(posedge clock) begin
        if (reset) begin
            eng                    <= eng_idle;
            sh                     <= '0;
            hold_q                 <= 1'b0;
            bitn                   <= 5'h0;
            timer                  <= '0;
            link.serial_prog_clock <= 1'b0;
            link.data_host_out     <= 1'b0;
            link.data_host_oe      <= 1'b0;
        end else begin
            unique case (eng)
                eng_idle: begin
                    if (phase != ph_idle) begin
                        sh                     <= {cmd.payload, cmd.code};
                        hold_q                 <= cmd.hold;
                        bitn                   <= 5'h0;
                        timer                  <= TW'(HALF_CYC);
                        eng                    <= eng_high;
                        link.serial_prog_clock <= 1'b1;
                        link.data_host_out     <= cmd.code[0];
                        link.data_host_oe      <= 1'b1;
                    end
                end
                eng_high: begin
                    if (timer == TW'(1)) begin
                        eng                    <= eng_low;
                        link.serial_prog_clock <= 1'b0;
                        if (hold_q && bitn == 5'(HOLD_BIT)) begin
                            timer <= TW'(DISCH_CYC);
                        end else begin
                            timer <= TW'(HALF_CYC);
                        end
                    end else begin
                        timer <= timer - TW'(1);
                    end
                end
                eng_low: begin
                    if (timer != TW'(1)) begin
                        timer <= timer - TW'(1);
                    end else if (bitn == 5'(FRAME_BITS - 1)) begin
                        eng               <= eng_idle;
                        link.data_host_oe <= 1'b0;
                    end else begin
                        bitn                   <= bitn + 5'h1;
                        sh                     <= {1'b0, sh[FRAME_BITS-1:1]};
                        link.data_host_out     <= sh[1];
                        link.serial_prog_clock <= 1'b1;
                        eng                    <= eng_high;
                        if (hold_q && bitn == 5'(HOLD_BIT - 1)) begin
                            timer <= TW'(PROG_HOLD_CYC);
                        end else begin
                            timer <= TW'(HALF_CYC);
                        end
                    end
                end
            endcase
        end
    end
endmodule : cmms_programmer

// ===== cmms_pkg.sv
// Shared constants and types for the code memory modify sequencer
package cmms_pkg;
    // Timing, in the unit named, and derived clock counts
    localparam int CLK_NS            = 40;
    localparam int LINK_HALF_NS      = 160;
    localparam int PROG_HOLD_NS      = 1_000_000;
    localparam int DISCH_HOLD_NS     = 100_000;
    localparam int DEF_HALF_CYC      = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEF_PROG_HOLD_CYC = (PROG_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEF_DISCH_CYC     = (DISCH_HOLD_NS + CLK_NS - 1) / CLK_NS;

    // Buffer geometry
    localparam int DEF_WRITE_BYTES = 64;
    localparam int DEF_ERASE_BYTES = 64;
    localparam int PTR_W           = 22;

    // Frame layout
    localparam int CMD_BITS   = 4;
    localparam int PAY_BITS   = 16;
    localparam int FRAME_BITS = CMD_BITS + PAY_BITS;
    localparam int HOLD_BIT   = 3;

    // Four-bit commands
    localparam logic [3:0] CMD_CORE       = 4'h0;
    localparam logic [3:0] CMD_LOAD_INC   = 4'hD;
    localparam logic [3:0] CMD_LOAD_START = 4'hF;

    // Core instruction fields
    localparam logic [7:0] OP_MOVLW  = 8'h0E;
    localparam logic [7:0] OP_MOVWF  = 8'h6E;
    localparam logic [3:0] OP_BSF    = 4'h8;
    localparam logic [3:0] OP_BCF    = 4'h9;
    localparam logic [7:0] REG_CTRL  = 8'hA6;
    localparam logic [7:0] REG_PTR_U = 8'hF8;
    localparam logic [7:0] REG_PTR_H = 8'hF7;
    localparam logic [7:0] REG_PTR_L = 8'hF6;

    // Whole core instructions the programmer sends
    localparam logic [15:0] INS_SEL_PGM   = 16'h8EA6;
    localparam logic [15:0] INS_CLR_CFG   = 16'h9CA6;
    localparam logic [15:0] INS_SET_WR_EN = 16'h84A6;
    localparam logic [15:0] INS_SET_FREE  = 16'h88A6;
    localparam logic [15:0] INS_SET_WR    = 16'h82A6;
    localparam logic [15:0] INS_CLR_WR_EN = 16'h94A6;
    localparam logic [15:0] INS_NOP       = 16'h0000;

    // flash_control_reg bit positions and reset value
    localparam int         CTL_PGM   = 7;
    localparam int         CTL_CFG   = 6;
    localparam int         CTL_FREE  = 4;
    localparam int         CTL_WR_EN = 2;
    localparam int         CTL_WR    = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    typedef struct packed {
        logic        hold;
        logic [3:0]  code;
        logic [15:0] payload;
    } cmms_cmd_t;
endpackage : cmms_pkg

// ===== cmms_link_if.sv
// Serial programming link between programmer and device
`timescale 1ns/1ps
interface cmms_link_if;
    logic serial_prog_clock;
    logic data_host_out;
    logic data_host_oe;
    logic data_dev_out;
    logic data_dev_oe;
    logic serial_prog_data;

    // Undriven data line floats high
    assign serial_prog_data = data_host_oe ? data_host_out : (data_dev_oe ? data_dev_out : 1'b1);

    modport programmer (output serial_prog_clock, output data_host_out, output data_host_oe,
                        input serial_prog_data);
    modport device (input serial_prog_clock, input serial_prog_data,
                    output data_dev_out, output data_dev_oe);
endinterface : cmms_link_if

// ===== cmms_device.sv
// Device end: serial command decoder, write buffer and array strobes
`timescale 1ns/1ps
module cmms_device import cmms_pkg::*; #(
    parameter int WRITE_BYTES = DEF_WRITE_BYTES,
    parameter int ERASE_BYTES = DEF_ERASE_BYTES
) (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset,
    // Programming mode enable pin
    input  wire logic                     prog_mode_en,
    // Link
    cmms_link_if.device                   link,
    // Array strobes
    output logic                          array_erase,
    output logic                          array_program,
    output logic [PTR_W-1:0]              array_addr,
    output logic [WRITE_BYTES*8-1:0]      array_data,
    // State
    output logic [7:0]                    flash_control_reg,
    output logic [PTR_W-1:0]              table_pointer
);
    localparam int WB_W = $clog2(WRITE_BYTES);

    if (WRITE_BYTES < 2 || (1 << WB_W) != WRITE_BYTES || ERASE_BYTES < WRITE_BYTES
        || (1 << $clog2(ERASE_BYTES)) != ERASE_BYTES) begin : g_check
        $error("cmms_device: buffer sizes must be powers of two, erase >= write >= 2");
    end

    logic [1:0]            clk_sync;
    logic [1:0]            dat_sync;
    logic [1:0]            mode_sync;
    logic                  clk_q;
    logic [4:0]            bitn;
    logic [FRAME_BITS-1:0] shreg;
    logic [7:0]            wreg;
    logic                  armed;
    logic                  op_erase;
    logic [7:0]            wbuf [WRITE_BYTES];

    wire                  clk_s     = clk_sync[1];
    wire                  rise      = clk_s & ~clk_q;
    wire                  fall      = ~clk_s & clk_q;
    wire                  frame_end = fall && (bitn == 5'(FRAME_BITS - 1));
    wire [FRAME_BITS-1:0] word      = {dat_sync[1], shreg[FRAME_BITS-1:1]};
    wire [3:0]            code      = word[3:0];
    wire [15:0]           pay       = word[19:4];
    wire                  op_start  = rise && (bitn == 5'(HOLD_BIT)) && armed;
    wire                  op_end    = fall && (array_erase || array_program);
    wire                  code_sel  = flash_control_reg[CTL_PGM] && !flash_control_reg[CTL_CFG];
    wire [WB_W-1:0]       bidx      = {table_pointer[WB_W-1:1], 1'b0};

    always_ff @(posedge clock) begin
        if (reset) begin
            clk_sync  <= 2'h0;
            dat_sync  <= 2'h0;
            mode_sync <= 2'h0;
            clk_q     <= 1'b0;
        end else begin
            clk_sync  <= {clk_sync[0], link.serial_prog_clock};
            dat_sync  <= {dat_sync[0], link.serial_prog_data};
            mode_sync <= {mode_sync[0], prog_mode_en};
            clk_q     <= clk_s;
        end
    end

    // Four command bits then sixteen payload bits, LSB first, taken on falling clock
    always_ff @(posedge clock) begin
        if (reset || !mode_sync[1]) begin
            bitn  <= 5'h0;
            shreg <= '0;
        end else if (fall) begin
            bitn  <= (bitn == 5'(FRAME_BITS - 1)) ? 5'h0 : bitn + 5'h1;
            shreg <= word;
        end
    end

    // Core instructions, table pointer and arming
    always_ff @(posedge clock) begin
        if (reset || !mode_sync[1]) begin
            flash_control_reg <= CTL_RESET;
            table_pointer     <= '0;
            wreg              <= 8'h00;
            armed             <= 1'b0;
            op_erase          <= 1'b0;
        end else if (op_end) begin
            flash_control_reg[CTL_WR]   <= 1'b0;
            flash_control_reg[CTL_FREE] <= 1'b0;
            armed                       <= 1'b0;
        end else if (frame_end) begin
            if (code == CMD_CORE) begin
                if (pay[15:8] == OP_MOVLW) begin
                    wreg <= pay[7:0];
                end else if (pay[15:8] == OP_MOVWF) begin
                    if (pay[7:0] == REG_PTR_U) begin
                        table_pointer[21:16] <= wreg[5:0];
                    end else if (pay[7:0] == REG_PTR_H) begin
                        table_pointer[15:8] <= wreg;
                    end else if (pay[7:0] == REG_PTR_L) begin
                        table_pointer[7:0] <= wreg;
                    end
                end else if (pay[7:0] == REG_CTRL && pay[15:12] == OP_BCF) begin
                    flash_control_reg[pay[11:9]] <= 1'b0;
                end else if (pay[7:0] == REG_CTRL && pay[15:12] == OP_BSF) begin
                    if (pay[11:9] != 3'(CTL_WR)) begin
                        flash_control_reg[pay[11:9]] <= 1'b1;
                    end else if (flash_control_reg[CTL_WR_EN] && code_sel) begin
                        flash_control_reg[CTL_WR] <= 1'b1;
                        armed                     <= 1'b1;
                        op_erase                  <= flash_control_reg[CTL_FREE];
                    end
                end
            end else if (code == CMD_LOAD_INC) begin
                table_pointer <= table_pointer + PTR_W'(2);
            end else if (code == CMD_LOAD_START && flash_control_reg[CTL_WR_EN] && code_sel) begin
                armed    <= 1'b1;
                op_erase <= 1'b0;
            end
        end
    end

    // Write buffer: low byte at the pointer, high byte above it
    always_ff @(posedge clock) begin
        if (frame_end && (code == CMD_LOAD_INC || code == CMD_LOAD_START)) begin
            wbuf[bidx]         <= pay[7:0];
            wbuf[bidx | WB_W'(1)] <= pay[15:8];
        end
    end

    // Array pulse lasts while the fourth clock of the following command is high
    always_ff @(posedge clock) begin
        if (reset || !mode_sync[1]) begin
            array_erase   <= 1'b0;
            array_program <= 1'b0;
            array_addr    <= '0;
            array_data    <= '0;
        end else if (op_start) begin
            array_erase   <= op_erase;
            array_program <= !op_erase;
            if (op_erase) begin
                array_addr <= table_pointer & ~PTR_W'(ERASE_BYTES - 1);
            end else begin
                array_addr <= table_pointer & ~PTR_W'(WRITE_BYTES - 1);
            end
            for (int i = 0; i < WRITE_BYTES; i++) begin
                array_data[i*8 +: 8] <= wbuf[i];
            end
        end else if (op_end) begin
            array_erase   <= 1'b0;
            array_program <= 1'b0;
        end
    end

    // The device never drives data in this sequence
    always_ff @(posedge clock) begin
        if (reset) begin
            link.data_dev_out <= 1'b0;
            link.data_dev_oe  <= 1'b0;
        end else begin
            link.data_dev_out <= 1'b0;
            link.data_dev_oe  <= 1'b0;
        end
    end
endmodule : cmms_device

// ===== cmms_link_monitor.sv
// Link checker: frame shape, clock widths and line ownership
`timescale 1ns/1ps
module cmms_link_monitor #(
    parameter int HALF_CYC      = 4,
    parameter int PROG_HOLD_CYC = 40,
    parameter int DISCH_CYC     = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Link
    input wire logic serial_prog_clock,
    input wire logic data_host_out,
    input wire logic data_host_oe,
    input wire logic data_dev_out,
    input wire logic data_dev_oe,
    input wire logic serial_prog_data
);
    int   hi_cnt, lo_cnt, bit_cnt;
    logic clk_d, long_hi;
    always_ff @(posedge clock) begin
        hi_cnt <= reset || !serial_prog_clock ? 0 : hi_cnt + 1;
        lo_cnt <= reset ? HALF_CYC : (serial_prog_clock ? 0 : lo_cnt + 1);
        clk_d  <= reset ? 1'b0 : serial_prog_clock;
    end
    // Remembers whether the last high phase was a programming hold
    always_ff @(posedge clock) begin
        if (reset) long_hi <= 1'b0;
        else if (clk_d && !serial_prog_clock) long_hi <= (hi_cnt == PROG_HOLD_CYC);
    end
    always_ff @(posedge clock) begin
        if (reset || !data_host_oe) bit_cnt <= 0;
        else if (serial_prog_clock && !clk_d) bit_cnt <= bit_cnt + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_dev_never_drives: assert property (!data_dev_oe) else $error("device drove data");
    a_idle_clock_low: assert property (!data_host_oe |-> !serial_prog_clock) else $error("clock outside frame");
    a_data_resolved: assert property (data_host_oe |-> serial_prog_data == data_host_out) else $error("data line");
    a_data_held_high: assert property (serial_prog_clock && clk_d |-> $stable(data_host_out)) else $error("data moved");
    a_high_width: assert property ($fell(serial_prog_clock) |-> hi_cnt == HALF_CYC || hi_cnt == PROG_HOLD_CYC)
        else $error("clock high width");
    a_hold_fourth_bit: assert property ($fell(serial_prog_clock) && hi_cnt != HALF_CYC |-> bit_cnt == 4)
        else $error("hold not on fourth clock");
    a_low_width: assert property ($rose(serial_prog_clock) |-> lo_cnt >= (long_hi ? DISCH_CYC : HALF_CYC))
        else $error("clock low too short");
    a_frame_length: assert property ($fell(data_host_oe) |-> bit_cnt == 20) else $error("frame length");
    c_long_hold: cover property ($fell(serial_prog_clock) && hi_cnt == PROG_HOLD_CYC);
    c_frame_done: cover property ($fell(data_host_oe));
    c_data_one: cover property (data_host_oe && data_host_out);
endmodule : cmms_link_monitor

// ===== code_memory_modify_sequencer_test.sv
// Testbench: programmer and device rewrite two blocks in turn over the link
`timescale 1ns/1ps
module code_memory_modify_sequencer_test import cmms_pkg::*;;
    localparam int W = 8, E = 16, PH = 40, DC = 20;
    logic clock = 0, reset = 1, prog_mode_en = 0, load_we = 0, start = 0, busy, done, array_erase, array_program;
    logic [3:0] load_index = 4'h0;
    logic [7:0] load_byte = 8'h00, flash_control_reg, blk [E];
    logic [PTR_W-1:0] block_addr = '0, array_addr, table_pointer, exp_base;
    logic [W*8-1:0] array_data;
    logic pe = 0, pp = 0;
    int num_errors = 0, compares = 0, n_prog, n_erase, hi, t;
    always #20 clock = ~clock;
    cmms_link_if link();
    cmms_programmer #(.WRITE_BYTES(W), .ERASE_BYTES(E), .HALF_CYC(4), .PROG_HOLD_CYC(PH), .DISCH_CYC(DC))
    u_cmms_programmer (.clock(clock), .reset(reset), .load_we(load_we), .load_index(load_index),
        .load_byte(load_byte), .start(start), .block_addr(block_addr), .busy(busy), .done(done), .link(link));
    cmms_device #(.WRITE_BYTES(W), .ERASE_BYTES(E)) u_cmms_device (.clock(clock), .reset(reset),
        .prog_mode_en(prog_mode_en), .link(link), .array_erase(array_erase), .array_program(array_program),
        .array_addr(array_addr), .array_data(array_data), .flash_control_reg(flash_control_reg),
        .table_pointer(table_pointer));
    cmms_link_monitor #(.HALF_CYC(4), .PROG_HOLD_CYC(PH), .DISCH_CYC(DC)) u_cmms_link_monitor (.clock(clock),
        .reset(reset), .serial_prog_clock(link.serial_prog_clock), .data_host_out(link.data_host_out),
        .data_host_oe(link.data_host_oe), .data_dev_out(link.data_dev_out), .data_dev_oe(link.data_dev_oe),
        .serial_prog_data(link.serial_prog_data));
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // Array strobes against the block model
    always @(posedge clock) begin
        if (array_erase && !pe) begin
            n_erase++;
            check("erase addr", array_addr, exp_base);
            check("write enable at erase", flash_control_reg[CTL_WR_EN], 1'b1);
        end
        if (array_program && !pp) begin
            check("prog addr", array_addr, PTR_W'(exp_base + n_prog * W));
            check("write enable at prog", flash_control_reg[CTL_WR_EN], 1'b1);
            for (int i = 0; i < W; i++) check("prog byte", array_data[8*i+:8], blk[n_prog*W+i]);
            n_prog++;
            hi = 0;
        end
        if (array_program) hi++;
        if (!array_program && pp) check("prog width", hi, PH);
        pe <= array_erase;
        pp <= array_program;
    end
    initial begin
        void'($urandom(61));
        repeat (4) @(negedge clock);
        reset = 0;
        prog_mode_en = 1;
        repeat (4) @(negedge clock);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < E; i++) begin
                blk[i] = 8'($urandom);
                load_we = 1;
                load_index = 4'(i);
                load_byte = blk[i];
                @(negedge clock);
            end
            n_prog = 0;
            n_erase = 0;
            block_addr = PTR_W'($urandom);
            exp_base = {block_addr[PTR_W-1:4], 4'h0};
            start = 1;
            load_we = 0;
            @(negedge clock);
            start = 0;
            check("busy", busy, 1'b1);
            // Garbage loads while busy must not reach the block copy
            for (t = 0; t < 20000 && done !== 1'b1; t++) begin
                load_we = 1;
                load_index = 4'($urandom);
                load_byte = 8'($urandom);
                @(negedge clock);
            end
            load_we = 0;
            if (t == 20000) begin
                num_errors++;
                break;
            end
            check("busy after done", busy, 1'b0);
            check("erases", n_erase, 1);
            check("programs", n_prog, E / W);
            check("pointer", table_pointer, PTR_W'(exp_base + E - 2));
            check("control", flash_control_reg, 8'h80);
            // Dropping the mode pin must clear the device state
            prog_mode_en = 0;
            repeat (4) @(negedge clock);
            check("mode drop", {flash_control_reg, table_pointer}, 64'h0);
            prog_mode_en = 1;
            repeat (4) @(negedge clock);
        end
        test_done();
    end
endmodule : code_memory_modify_sequencer_test
